/* File: bench/cbt_bit_timing_tb.sv */
/*
  cbt_bit_timing_tb: register, bit length and synchronisation checks.
  Assumes the node model alone drives canRx and a 40 MHz clock.
*/
`timescale 1ns/1ps
module cbt_bit_timing_tb;
  logic        clock = 1'b0, reset_n = 1'b0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rd;
  logic [3:0]  wstrb = '0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, canRx, canTx;
  logic        txBitNext = 1'b1, samplePoint, sampledBit, bitStart, busIdle;
  logic [1:0]  bresp, rresp, rs;
  int          numErrors = 0, nTests = 0, n;
  real         t0;
  // sweep: config words and bit length in clocks; last two
  logic [15:0] cfgTab [5] = '{16'h2301, 16'h7f00, 16'h011f, 16'h34c1, 16'h3fc0};
  int          clkTab [5] = '{16, 25, 128, 20, 21};

  // free running 40 MHz clock
  initial begin
    forever #12.5 clock = ~clock;
  end

  cbt_bit_timing dut_u (.clock(clock), .reset_n(reset_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .canRx(canRx), .canTx(canTx), .txBitNext(txBitNext),
    .samplePoint(samplePoint), .sampledBit(sampledBit), .bitStart(bitStart),
    .busIdle(busIdle));

  cbt_node_model node_u (.clock(clock), .devTx(canTx), .devBitStart(bitStart),
    .busLevel(canRx));

  // verdict and end of run, shared with the watchdog
  task automatic wrapUp();
    $display("comparisons %0d mismatches %0d", nTests, numErrors);
    if (numErrors == 0 && nTests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // data compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      numErrors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // response code compare
  task automatic chkr(input logic [1:0] got, input logic [1:0] exp);
    nTests++;
    if (got !== exp) begin
      numErrors++;
      $display("BAD t=%0t resp got=%h exp=%h", $time, got, exp);
    end
  endtask

  // write: address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask

  // read: data and response taken at the rvalid edge
  task automatic axi_rd(input logic [11:0] a);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  // clocks until the next bit start, capped at lim
  task automatic gap(input int lim);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (bitStart !== 1'b1 && n < lim);
  endtask

  // next sample point pulse
  task automatic wait_sp();
    do @(posedge clock); while (samplePoint !== 1'b1);
  endtask

  // stop, load a config word, start again
  task automatic set_cfg(input logic [15:0] c);
    axi_wr(cbt_pkg::CBT_OFF_CONTROL, 32'h0, 4'h1);
    axi_wr(cbt_pkg::CBT_OFF_CONFIG, {16'h0, c}, 4'h3);
    axi_wr(cbt_pkg::CBT_OFF_CONTROL, 32'h1, 4'h1);
  endtask

  // main sequence
  initial begin
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    axi_rd(cbt_pkg::CBT_OFF_CONFIG);
    chk(rd, 32'h2301);
    axi_rd(cbt_pkg::CBT_OFF_CONTROL);
    chk(rd, 32'h0);
    axi_rd(cbt_pkg::CBT_OFF_STATUS);
    chk(rd, 32'h38);
    axi_rd(12'h010);
    chkr(rs, cbt_pkg::CBT_RESP_SLVERR);
    chk(rd, 32'h0);
    axi_wr(cbt_pkg::CBT_OFF_STATUS, 32'h0, 4'hf);
    chkr(rs, cbt_pkg::CBT_RESP_SLVERR);
    axi_wr(12'h010, 32'h0, 4'hf);
    chkr(rs, cbt_pkg::CBT_RESP_SLVERR);
    axi_wr(cbt_pkg::CBT_OFF_CONFIG, 32'hffffffff, 4'hf);
    chkr(rs, cbt_pkg::CBT_RESP_OKAY);
    axi_rd(cbt_pkg::CBT_OFF_CONFIG);
    chk(rd, 32'h7fff);
    // upper lane only: prescaler and jump width bytes must survive
    axi_wr(cbt_pkg::CBT_OFF_CONFIG, 32'h0, 4'h2);
    axi_rd(cbt_pkg::CBT_OFF_CONFIG);
    chk(rd, 32'h00ff);
    // stopped: the quantum never ticks, so no bit begins
    gap(300);
    chk(32'(n), 32'd300);
    // idle recessive bus: bit length is fields plus three quanta
    for (int i = 0; i < 5; i++) begin
      set_cfg(cfgTab[i]);
      gap(2000);
      gap(2000);
      chk(32'(n), 32'(clkTab[i]));
    end
    // 2 clocks a quantum, seg1 4, seg2 6, jump 1: 22 clocks a bit
    set_cfg(16'h5301);
    gap(2000);
    repeat (5) @(posedge clock);
    node_u.drive(1'b0);
    gap(2000);
    chk({31'h0, n <= 5}, 32'h1);
    wait_sp();
    @(posedge clock);
    chk({31'h0, sampledBit}, 32'h0);
    node_u.drive(1'b1);
    @(posedge clock);
    chk({31'h0, busIdle}, 32'h0);
    // late edge in seg1: bit grows by one jump width
    fork
      node_u.edge_after_start(4, 6);
      begin
        gap(2000);
        gap(2000);
      end
    join
    chk(32'(n), 32'd24);
    // early edge in seg2: bit shrinks by one jump width
    fork
      node_u.edge_after_start(12, 4);
      begin
        gap(2000);
        gap(2000);
      end
    join
    chk(32'(n), 32'd20);
    // transmit bit taken at the sample point, driven from the next sync on
    txBitNext <= 1'b0;
    wait_sp();
    txBitNext <= 1'b1;
    gap(2000);
    t0 = $realtime;
    @(posedge clock);
    chk({31'h0, canTx}, 32'h0);
    wait_sp();
    chk({31'h0, canTx}, 32'h0);
    gap(2000);
    // our own dominant edge falls in sync, so the bit keeps its length
    chk(32'(int'(($realtime - t0) / 25.0)), 32'd22);
    @(posedge clock);
    chk({31'h0, canTx}, 32'h1);
    wrapUp();
  end

  // watchdog: whole sequence needs well under 20000 clocks
  initial begin
    #(60000 * 25);
    numErrors++;
    wrapUp();
  end
endmodule

/* File: bench/cbt_node_model.sv */
/*
  cbt_node_model: a second node on the shared bus, wired-and with the device.
  Assumes the bench calls its tasks in the clock domain of the device.
*/
`timescale 1ns/1ps
module cbt_node_model (
  input  wire logic clock,
  input  wire logic devTx,
  input  wire logic devBitStart,
  output logic      busLevel
);
  logic nodeTx = 1'b1;  // own drive, 1 = released

  // dominant wins; a released bus returns to recessive, as with a real bus
  assign busLevel = devTx & nodeTx;

  // plain level change, called just after an edge
  task automatic drive(input logic lvl);
    nodeTx <= lvl;
  endtask

  // falling edge d clocks after a device bit start, held h clocks
  // edges are whole clocks, so the phase error is known to a quantum
  task automatic edge_after_start(input int d, input int h);
    do @(posedge clock); while (devBitStart !== 1'b1);
    repeat (d) @(posedge clock);
    nodeTx <= 1'b0;
    repeat (h) @(posedge clock);
    nodeTx <= 1'b1;
  endtask
endmodule

/* File: include/cbt_pkg.sv */
/*
  cbt_pkg: constants shared by the CAN bit timing block.
  Assumes a 32-bit AXI4-Lite register bus and a 40 MHz module clock.
*/
package cbt_pkg;
  // register byte offsets
  localparam logic [11:0] CBT_OFF_CONFIG  = 12'h00c;  // bit timing configuration
  localparam logic [11:0] CBT_OFF_CONTROL = 12'h004;  // run control
  localparam logic [11:0] CBT_OFF_STATUS  = 12'h008;  // live state, read only

  // configuration word field positions
  localparam int CBT_BRP_LSB  = 0;   // prescaler minus one, 6 bits
  localparam int CBT_SJW_LSB  = 6;   // jump width minus one, 2 bits
  localparam int CBT_SEG1_LSB = 8;   // segment before sample minus one, 4 bits
  localparam int CBT_SEG2_LSB = 12;  // segment after sample minus one, 3 bits
  localparam logic [15:0] CBT_CONFIG_MASK  = 16'h7fff;  // bit 15 reserved
  localparam logic [15:0] CBT_CONFIG_RESET = 16'h2301;  // value after reset
  localparam logic        CBT_RUN_RESET    = 1'b0;      // stopped after reset

  // bus idle detection: recessive bits in a row
  localparam logic [3:0] CBT_IDLE_BITS = 4'hb;

  // axi responses
  localparam logic [1:0] CBT_RESP_OKAY   = 2'h0;
  localparam logic [1:0] CBT_RESP_SLVERR = 2'h2;

  // register selector produced by the address decoder
  typedef enum logic [1:0] {CBT_SEL_CONFIG, CBT_SEL_CONTROL, CBT_SEL_STATUS,
                            CBT_SEL_NONE} cbt_sel_t;

  // segment states of one bit
  typedef enum logic [1:0] {CBT_SYNC, CBT_SEG1, CBT_SEG2} cbt_state_t;
endpackage

/* File: src/cbt_bit_timing.sv */
/*
  cbt_bit_timing: time quantum prescaler, bit segment sequencer with hard
  and re-synchronisation, sample point and transmit bit hand-off, behind an
  AXI4-Lite register slave.
  Assumes canRx and txBitNext are synchronous to clock; the frame level
  engine (stuffing, crc, errors) sits outside and feeds txBitNext.
*/
// How it works
// - quantum is prescaler field plus one clocks
// - bit runs sync, prop, phase one, phase two
// - propagation segment spans one to eight quanta
// - late edge lengthens first phase buffer
// - early edge shortens second phase buffer
// - jump width one to four, within phases
// - one resync shift limited by jump width
// - phase error is distance from sync
// - fields hold functional value minus one
// - bit time is seg1 plus seg2 plus three
// - fields packed seg2, seg1, jump, prescaler
// - sequencer evaluated once per time quantum
// - idle detector chooses hard or soft synchronisation
// - sample point takes rx, picks tx bit
// - processing time is zero quanta
// - short phase two keeps bus timing right
// - bit holds three to twenty-five quanta
// - rates 25 to 1000 kbit/s at 40 MHz
`timescale 1ns/1ps
module cbt_bit_timing #(
  parameter int ADDR_W = 12  // axi address width
) (
  input  wire logic              clock,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              canRx,
  output logic                   canTx,
  input  wire logic              txBitNext,
  output logic                   samplePoint,
  output logic                   sampledBit,
  output logic                   bitStart,
  output logic                   busIdle
);

  // address decode, shared by read and write paths
  function automatic cbt_pkg::cbt_sel_t decodeSel(input logic [ADDR_W-1:0] a);
    logic [11:0] off;
    off = 12'(a);
    if (off == cbt_pkg::CBT_OFF_CONFIG) decodeSel = cbt_pkg::CBT_SEL_CONFIG;
    else if (off == cbt_pkg::CBT_OFF_CONTROL) decodeSel = cbt_pkg::CBT_SEL_CONTROL;
    else if (off == cbt_pkg::CBT_OFF_STATUS) decodeSel = cbt_pkg::CBT_SEL_STATUS;
    else decodeSel = cbt_pkg::CBT_SEL_NONE;
  endfunction

  // smaller of two quanta counts
  function automatic logic [4:0] minQ(input logic [4:0] a, input logic [4:0] b);
    minQ = (a < b) ? a : b;
  endfunction

  // registers
  logic [15:0]       config_reg;    // bit timing configuration word
  logic              run_reg;       // sequencer enable
  logic [ADDR_W-1:0] awAddr_reg;    // captured write address
  logic              awHeld_reg;    // write address taken
  logic [31:0]       wData_reg;     // captured write data
  logic [3:0]        wStrb_reg;     // captured byte enables
  logic              wHeld_reg;     // write data taken
  logic [5:0]        preCnt_reg;    // prescaler counter
  logic              qTick_reg;     // one clock per quantum
  cbt_pkg::cbt_state_t state_reg;   // current segment
  logic [4:0]        cnt_reg;       // quanta done in segment
  logic [4:0]        lim_reg;       // length of current segment
  logic              rxPrev_reg;    // bus level one quantum ago
  logic              synced_reg;    // resync already used in this bit
  logic              txLatch_reg;   // bit to drive at next sync
  logic [3:0]        idleCnt_reg;   // recessive bits in a row

  // field extraction; every field holds functional value minus one
  wire logic [5:0] brpField  = config_reg[cbt_pkg::CBT_BRP_LSB +: 6];
  wire logic [1:0] sjwField  = config_reg[cbt_pkg::CBT_SJW_LSB +: 2];
  wire logic [3:0] seg1Field = config_reg[cbt_pkg::CBT_SEG1_LSB +: 4];
  wire logic [2:0] seg2Field = config_reg[cbt_pkg::CBT_SEG2_LSB +: 3];
  // functional lengths in quanta; seg1 covers prop plus phase one
  wire logic [4:0] seg1Len = 5'({1'b0, seg1Field}) + 5'h01;
  wire logic [4:0] seg2Len = 5'({2'b00, seg2Field}) + 5'h01;
  wire logic [4:0] sjwLen  = 5'({3'b000, sjwField}) + 5'h01;

  // write path decode
  wire cbt_pkg::cbt_sel_t wSel = decodeSel(awAddr_reg);
  wire logic doWrite   = awHeld_reg && wHeld_reg && !s_axi_bvalid;
  wire logic wrConfig  = doWrite && (wSel == cbt_pkg::CBT_SEL_CONFIG);
  wire logic wrControl = doWrite && (wSel == cbt_pkg::CBT_SEL_CONTROL);
  wire logic wrBad     = (wSel == cbt_pkg::CBT_SEL_NONE) || (wSel == cbt_pkg::CBT_SEL_STATUS);
  // byte lanes apply to the two low bytes; reserved bit stays zero
  wire logic [15:0] laneMask  = {{8{wStrb_reg[1]}}, {8{wStrb_reg[0]}}};
  wire logic [15:0] configNew = ((config_reg & ~laneMask) | (wData_reg[15:0] & laneMask))
                                & cbt_pkg::CBT_CONFIG_MASK;

  // read path decode
  wire cbt_pkg::cbt_sel_t rSel = decodeSel(s_axi_araddr);
  wire logic [31:0] statusWord = {24'h000000, 1'b0, synced_reg, idleCnt_reg == cbt_pkg::CBT_IDLE_BITS,
                                  sampledBit, canTx, 1'b0, state_reg};
  wire logic [31:0] readWord =
      (rSel == cbt_pkg::CBT_SEL_CONFIG)  ? {16'h0000, config_reg} :
      (rSel == cbt_pkg::CBT_SEL_CONTROL) ? {31'h00000000, run_reg} :
      (rSel == cbt_pkg::CBT_SEL_STATUS)  ? statusWord : 32'h00000000;

  // sequencer decode, all terms but preWrap used only on a quantum tick
  wire logic edgeSeen = rxPrev_reg && !canRx;                            // recessive to dominant
  wire logic hardSync = edgeSeen && busIdle;
  wire logic reSync   = edgeSeen && !busIdle && !synced_reg;
  // late edge: error counts quanta since sync ended
  wire logic [4:0] lateErr  = cnt_reg + 5'h01;
  wire logic [4:0] seg1Eff  = (reSync && state_reg == cbt_pkg::CBT_SEG1)
                              ? lim_reg + minQ(lateErr, sjwLen) : lim_reg;
  // early edge: error counts quanta left to next sync
  wire logic [4:0] earlyErr = lim_reg - cnt_reg;
  wire logic earlyRestart   = reSync && state_reg == cbt_pkg::CBT_SEG2 && earlyErr <= sjwLen;
  wire logic [4:0] seg2Eff  = (reSync && state_reg == cbt_pkg::CBT_SEG2 && !earlyRestart)
                              ? lim_reg - sjwLen : lim_reg;
  wire logic seg1Done = (state_reg == cbt_pkg::CBT_SEG1) && (lateErr >= seg1Eff);
  wire logic seg2Done = (state_reg == cbt_pkg::CBT_SEG2) && (cnt_reg + 5'h01 >= seg2Eff);
  wire logic preWrap  = (preCnt_reg == brpField);

  // configuration and control registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      config_reg <= cbt_pkg::CBT_CONFIG_RESET;
      run_reg    <= cbt_pkg::CBT_RUN_RESET;
    end else begin
      if (wrConfig) config_reg <= configNew;
      if (wrControl && wStrb_reg[0]) run_reg <= wData_reg[0];
    end
  end

  // write address and data capture, either order
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      awHeld_reg    <= 1'b0;
      wHeld_reg     <= 1'b0;
      awAddr_reg    <= '0;
      wData_reg     <= 32'h00000000;
      wStrb_reg     <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_reg    <= s_axi_awaddr;
        awHeld_reg    <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_reg    <= s_axi_wdata;
        wStrb_reg    <= s_axi_wstrb;
        wHeld_reg    <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      // held halves drop once the write is done
      if (doWrite) begin
        awHeld_reg <= 1'b0;
        wHeld_reg  <= 1'b0;
      end
      // readiness returns only after the response is accepted
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // write response
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= cbt_pkg::CBT_RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wrBad ? cbt_pkg::CBT_RESP_SLVERR : cbt_pkg::CBT_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read channel, one word per address
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= cbt_pkg::CBT_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= readWord;
      s_axi_rresp   <= (rSel == cbt_pkg::CBT_SEL_NONE) ? cbt_pkg::CBT_RESP_SLVERR
                                                       : cbt_pkg::CBT_RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // prescaler: a tick every brpField+1 clocks while running
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      preCnt_reg <= 6'h00;
      qTick_reg  <= 1'b0;
    end else begin
      qTick_reg  <= run_reg && preWrap;
      preCnt_reg <= (!run_reg || preWrap) ? 6'h00 : preCnt_reg + 6'h01;
    end
  end

  // segment sequencer, advanced only on a quantum tick
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg  <= cbt_pkg::CBT_SYNC;
      cnt_reg    <= 5'h00;
      lim_reg    <= 5'h01;
      rxPrev_reg <= 1'b1;
      synced_reg <= 1'b0;
    end else if (!run_reg && !qTick_reg) begin
      // stopped: park in sync so a new config never meets a stale limit
      state_reg  <= cbt_pkg::CBT_SYNC;
    end else if (qTick_reg) begin
      rxPrev_reg <= canRx;
      if (hardSync || earlyRestart) begin
        // edge quantum counts as the sync segment of a new bit
        state_reg  <= cbt_pkg::CBT_SEG1;
        cnt_reg    <= 5'h00;
        lim_reg    <= seg1Len;
        synced_reg <= 1'b1;
      end else begin
        if (reSync) synced_reg <= 1'b1;
        case (state_reg)
          cbt_pkg::CBT_SYNC: begin
            // sync segment lasts exactly one quantum
            state_reg  <= cbt_pkg::CBT_SEG1;
            cnt_reg    <= 5'h00;
            lim_reg    <= seg1Len;
            synced_reg <= 1'b0;
          end
          cbt_pkg::CBT_SEG1: begin
            if (seg1Done) begin
              state_reg <= cbt_pkg::CBT_SEG2;
              cnt_reg   <= 5'h00;
              lim_reg   <= seg2Len;
            end else begin
              cnt_reg <= cnt_reg + 5'h01;
              lim_reg <= seg1Eff;
            end
          end
          cbt_pkg::CBT_SEG2: begin
            // a shortened phase two may end at once; timing still holds
            if (seg2Done) begin
              state_reg <= cbt_pkg::CBT_SYNC;
              cnt_reg   <= 5'h00;
            end else begin
              cnt_reg <= cnt_reg + 5'h01;
              lim_reg <= seg2Eff;
            end
          end
          default: begin
            state_reg <= cbt_pkg::CBT_SYNC;
            cnt_reg   <= 5'h00;
          end
        endcase
      end
    end
  end

  // sample point and transmit hand-off; zero processing time needed
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      samplePoint <= 1'b0;
      sampledBit  <= 1'b1;
      txLatch_reg <= 1'b1;
      bitStart    <= 1'b0;
      canTx       <= 1'b1;
    end else begin
      samplePoint <= qTick_reg && seg1Done && !hardSync && !earlyRestart;
      if (qTick_reg && seg1Done && !hardSync && !earlyRestart) begin
        sampledBit  <= canRx;
        txLatch_reg <= txBitNext;
      end
      // new bit begins at a sync quantum, a hard sync edge or an early edge that restarts the bit
      bitStart <= qTick_reg && (state_reg == cbt_pkg::CBT_SYNC || hardSync || earlyRestart);
      // drive the new level as sync begins, so our own edge falls in sync
      if (qTick_reg && (seg2Done || hardSync || earlyRestart))
        canTx <= txLatch_reg;
    end
  end

  // idle detector picks hard sync after a run of recessive bits
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      idleCnt_reg <= cbt_pkg::CBT_IDLE_BITS;
      busIdle     <= 1'b1;
    end else begin
      if (samplePoint) begin
        if (!sampledBit) idleCnt_reg <= 4'h0;
        else if (idleCnt_reg != cbt_pkg::CBT_IDLE_BITS) idleCnt_reg <= idleCnt_reg + 4'h1;
      end
      busIdle <= (idleCnt_reg == cbt_pkg::CBT_IDLE_BITS) && !(samplePoint && !sampledBit);
    end
  end

  // helper: quanta since the last bit start, for the bit length check
  logic [5:0] bitQuanta;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) bitQuanta <= 6'h00;
    else if (bitStart) bitQuanta <= 6'h00;
    else if (!run_reg) bitQuanta <= 6'h00;
    else if (qTick_reg && bitQuanta != 6'h3f) bitQuanta <= bitQuanta + 6'h01;
  end

  property p_prescale;
    @(posedge clock) disable iff (!reset_n)
      (run_reg && preWrap) |=> qTick_reg;
  endproperty
  a_prescale: assert property (p_prescale) else $error("quantum tick missing");

  property p_no_tick_stopped;
    @(posedge clock) disable iff (!reset_n)
      !run_reg |=> !qTick_reg;
  endproperty
  a_no_tick_stopped: assert property (p_no_tick_stopped) else $error("tick while stopped");

  property p_sync_one;
    @(posedge clock) disable iff (!reset_n)
      (qTick_reg && state_reg == cbt_pkg::CBT_SYNC) |=> state_reg == cbt_pkg::CBT_SEG1;
  endproperty
  a_sync_one: assert property (p_sync_one) else $error("sync not one quantum");

  property p_seg1_bound;
    @(posedge clock) disable iff (!reset_n)
      state_reg == cbt_pkg::CBT_SEG1 |-> lim_reg <= seg1Len + sjwLen;
  endproperty
  a_seg1_bound: assert property (p_seg1_bound) else $error("phase one over jump");

  property p_seg2_bound;
    @(posedge clock) disable iff (!reset_n)
      state_reg == cbt_pkg::CBT_SEG2 |-> lim_reg <= seg2Len;
  endproperty
  a_seg2_bound: assert property (p_seg2_bound) else $error("phase two lengthened");

  property p_sample_seg;
    @(posedge clock) disable iff (!reset_n)
      samplePoint |-> $past(state_reg) == cbt_pkg::CBT_SEG1 && state_reg == cbt_pkg::CBT_SEG2;
  endproperty
  a_sample_seg: assert property (p_sample_seg) else $error("sample off boundary");

  property p_tx_hand;
    @(posedge clock) disable iff (!reset_n)
      bitStart |-> canTx == $past(txLatch_reg);
  endproperty
  a_tx_hand: assert property (p_tx_hand) else $error("tx not from latch");

  property p_bit_len;
    @(posedge clock) disable iff (!reset_n)
      bitQuanta <= 6'(seg1Len) + 6'(seg2Len) + 6'(sjwLen) + 6'h01 || $past(wrConfig);
  endproperty
  a_bit_len: assert property (p_bit_len) else $error("bit too long");

  property p_cfg_write;
    @(posedge clock) disable iff (!reset_n)
      wrConfig |=> config_reg == $past(configNew);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config not stored");

  property p_bhold;
    @(posedge clock) disable iff (!reset_n)
      (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");

endmodule
